// ---- design/elm_pkg.sv ----
// shared constants and types for the encoder latch, monitor and event timer block
package elm_pkg;

  localparam int ELM_DW = 16;
  localparam int ELM_AW = 4;

  // register indexes on the plain register port
  localparam logic [3:0] ELM_REG_CTRL = 4'h0;
  localparam logic [3:0] ELM_REG_MAXCNT = 4'h1;
  localparam logic [3:0] ELM_REG_COUNT = 4'h2;
  localparam logic [3:0] ELM_REG_ILATCH = 4'h3;
  localparam logic [3:0] ELM_REG_SLATCH = 4'h4;
  localparam logic [3:0] ELM_REG_STATUS = 4'h5;
  localparam logic [3:0] ELM_REG_DIVIDER = 4'h6;
  localparam logic [3:0] ELM_REG_DECIM = 4'h7;
  localparam logic [3:0] ELM_REG_SNAP = 4'h8;
  localparam logic [3:0] ELM_REG_INTERVAL = 4'h9;
  localparam logic [3:0] ELM_REG_ELAPSED = 4'ha;
  localparam logic [3:0] ELM_REG_OVFSTAT = 4'hb;

  // encoder_control bit positions
  localparam int ELM_CTL_REVERSE = 0;
  localparam int ELM_CTL_ZERO = 1;
  localparam int ELM_CTL_SNM = 2;
  localparam int ELM_CTL_MON = 3;
  localparam int ELM_CTL_CAPSEL = 4;
  localparam int ELM_CTL_IDXMODE = 7;
  localparam int ELM_CTL_STBMODE = 8;
  localparam logic [15:0] ELM_CTL_MASK = 16'h019f;

  // encoder_status bit positions
  localparam int ELM_ST_ERROR = 0;
  localparam int ELM_ST_DIR = 1;
  localparam int ELM_ST_INPUTS = 3;
  localparam int ELM_ST_FIRST = 7;

  // reset values, plus the full-count and timer reload constants
  localparam logic [15:0] ELM_RST_CTRL = 16'h0000;
  localparam logic [15:0] ELM_RST_MAXCNT = 16'hffff;
  localparam logic [15:0] ELM_RST_ZERO = 16'h0000;
  localparam logic [7:0] ELM_RST_DECIM = 8'h00;
  localparam logic [15:0] ELM_CNT_FULL = 16'hffff;
  localparam logic [15:0] ELM_TIMER_ONE = 16'h0001;

  // input filter: samples that must agree before the filtered level moves
  localparam int ELM_FILT_STAGES = 3;

  // filtered encoder inputs, lowest bit first: a, b, index, strobe
  typedef struct packed {
    logic strobe;
    logic index;
    logic b;
    logic a;
  } elm_enc_t;

endpackage : elm_pkg

// ---- design/elm_encoder_unit.sv ----
// encoder position latches, marker reset, count monitor and event timer
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/100ps

module elm_encoder_unit
  import elm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic quadAPin,
  input wire logic quadBPin,
  input wire logic indexMarkerPin,
  input wire logic strobeMarkerPin,
  input wire logic loopTimeout,
  input wire logic [ELM_AW-1:0] regAddr,
  input wire logic [ELM_DW-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [ELM_DW-1:0] regRdData,
  output logic countErrorEvent
);

  logic [3:0] rawIn;
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  elm_enc_t filt_ff;
  elm_enc_t prev_ff;
  logic [15:0] ctrl_ff;
  logic [15:0] maxCnt_ff;
  logic [15:0] count_ff;
  logic [15:0] nxt_count;
  logic [15:0] idxLatch_ff;
  logic [15:0] stbLatch_ff;
  logic [15:0] divider_ff;
  logic [7:0] decim_ff;
  logic [15:0] divCnt_ff;
  logic [7:0] decCnt_ff;
  logic [15:0] timer_ff;
  logic [15:0] interval_ff;
  logic [15:0] snap_ff;
  logic [15:0] intervalRes_ff;
  logic [15:0] elapsed_ff;
  logic dirUp_ff;
  logic zeroArmed_ff;
  logic idxArmed_ff;
  logic firstSeen_ff;
  logic countErr_ff;
  logic overflow_ff;
  logic errEvent_ff;
  logic curA;
  logic curB;
  logic prvA;
  logic prvB;
  logic quadPulse;
  logic pulseUp;
  logic idxRise;
  logic idxFall;
  logic stbRise;
  logic stbFall;
  logic markerSeen;
  logic zeroReset;
  logic velEvent;
  logic divTick;
  logic timerOverflow;
  logic reversal;
  logic eetWrite;
  logic capture;
  logic [15:0] expected;

  assign rawIn = {strobeMarkerPin, indexMarkerPin, quadBPin, quadAPin};

  // two-stage synchroniser, then a level filter that needs agreeing samples
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
      prev_ff <= '0;
    end
    else
    begin
      sync1_ff <= rawIn;
      sync2_ff <= sync1_ff;
      prev_ff <= filt_ff;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_filter
      logic [ELM_FILT_STAGES-1:0] hist_ff;
      logic level_ff;
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          hist_ff <= '0;
          level_ff <= 1'b0;
        end
        else
        begin
          hist_ff <= {hist_ff[ELM_FILT_STAGES-2:0], sync2_ff[gi]};
          if (&hist_ff)
            level_ff <= 1'b1;
          else if (~|hist_ff)
            level_ff <= 1'b0;
        end
      end
      assign filt_ff[gi] = level_ff;
    end
  endgenerate

  // reverse bit swaps the pins into the counter's a and b
  assign curA = ctrl_ff[ELM_CTL_REVERSE] ? filt_ff.b : filt_ff.a;
  assign curB = ctrl_ff[ELM_CTL_REVERSE] ? filt_ff.a : filt_ff.b;
  assign prvA = ctrl_ff[ELM_CTL_REVERSE] ? prev_ff.b : prev_ff.a;
  assign prvB = ctrl_ff[ELM_CTL_REVERSE] ? prev_ff.a : prev_ff.b;
  // a double change is an illegal transition and is dropped rather than guessed
  assign quadPulse = (curA ^ prvA) ^ (curB ^ prvB);
  assign pulseUp = curA ^ prvB;

  assign idxRise = filt_ff.index & ~prev_ff.index;
  assign idxFall = ~filt_ff.index & prev_ff.index;
  assign stbRise = filt_ff.strobe & ~prev_ff.strobe;
  assign stbFall = ~filt_ff.strobe & prev_ff.strobe;
  assign markerSeen = dirUp_ff ? idxRise : idxFall;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dirUp_ff <= 1'b1;
    else if (quadPulse)
      dirUp_ff <= pulseUp;
  end

  assign expected = dirUp_ff ? ELM_RST_ZERO : maxCnt_ff;

  // marker reset waits for the next pulse so the reset stays on one encoder edge
  assign zeroReset = quadPulse & zeroArmed_ff & ctrl_ff[ELM_CTL_ZERO];

  always_comb
  begin
    nxt_count = count_ff;
    if (zeroReset)
      nxt_count = pulseUp ? ELM_RST_ZERO : maxCnt_ff;
    else if (quadPulse && pulseUp)
      nxt_count = (count_ff == maxCnt_ff) ? ELM_RST_ZERO : count_ff + 16'h0001;
    else if (quadPulse)
      nxt_count = (count_ff == ELM_RST_ZERO) ? maxCnt_ff : count_ff - 16'h0001;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_ff <= ELM_RST_ZERO;
    else
      count_ff <= nxt_count;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      zeroArmed_ff <= 1'b0;
      firstSeen_ff <= 1'b0;
    end
    else
    begin
      // single-north mode arms only at the first marker, so later markers leave the count
      if (markerSeen && (!ctrl_ff[ELM_CTL_SNM] || !firstSeen_ff))
        zeroArmed_ff <= 1'b1;
      else if (quadPulse)
        zeroArmed_ff <= 1'b0;
      if (markerSeen && ctrl_ff[ELM_CTL_ZERO])
        firstSeen_ff <= 1'b1;
    end
  end

  // index latch: plain edge mode or zero-marker style on the next pulse
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idxArmed_ff <= 1'b0;
      idxLatch_ff <= ELM_RST_ZERO;
    end
    else if (!ctrl_ff[ELM_CTL_IDXMODE])
    begin
      idxArmed_ff <= 1'b0;
      if (idxRise)
        idxLatch_ff <= count_ff;
    end
    else
    begin
      if (markerSeen)
        idxArmed_ff <= 1'b1;
      else if (quadPulse)
        idxArmed_ff <= 1'b0;
      if (quadPulse && idxArmed_ff)
        idxLatch_ff <= count_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stbLatch_ff <= ELM_RST_ZERO;
    else if (!ctrl_ff[ELM_CTL_STBMODE] && stbRise)
      stbLatch_ff <= count_ff;
    else if (ctrl_ff[ELM_CTL_STBMODE] && (dirUp_ff ? stbRise : stbFall))
      stbLatch_ff <= count_ff;
  end

  // count monitor; the counter keeps running whatever the verdict
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      countErr_ff <= 1'b0;
      errEvent_ff <= 1'b0;
    end
    else
    begin
      errEvent_ff <= 1'b0;
      if (markerSeen && ctrl_ff[ELM_CTL_MON] && ctrl_ff[ELM_CTL_ZERO])
      begin
        if (count_ff != expected)
        begin
          countErr_ff <= 1'b1;
          errEvent_ff <= 1'b1;
        end
        else
          countErr_ff <= 1'b0;
      end
    end
  end

  assign countErrorEvent = errEvent_ff;

  // event timer divider: counting 0..div-1 wraps to 65536 states when div is zero
  assign divTick = (divCnt_ff == divider_ff - 16'h0001);
  assign velEvent = quadPulse & (decCnt_ff == decim_ff - 8'h01);
  assign timerOverflow = divTick & (timer_ff == ELM_CNT_FULL);
  assign reversal = quadPulse & (pulseUp != dirUp_ff);
  assign eetWrite = regWr & ((regAddr == ELM_REG_DIVIDER) | (regAddr == ELM_REG_DECIM));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      divCnt_ff <= ELM_RST_ZERO;
    else if (eetWrite || divTick)
      divCnt_ff <= ELM_RST_ZERO;
    else
      divCnt_ff <= divCnt_ff + 16'h0001;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      decCnt_ff <= ELM_RST_DECIM;
    else if (eetWrite || velEvent)
      decCnt_ff <= ELM_RST_DECIM;
    else if (quadPulse)
      decCnt_ff <= decCnt_ff + 8'h01;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_ff <= ELM_RST_ZERO;
      interval_ff <= ELM_RST_ZERO;
    end
    else if (eetWrite)
    begin
      timer_ff <= ELM_RST_ZERO;
      interval_ff <= ELM_RST_ZERO;
    end
    else if (reversal)
    begin
      timer_ff <= ELM_TIMER_ONE;
      interval_ff <= ELM_CNT_FULL;
    end
    else if (velEvent)
    begin
      interval_ff <= timer_ff;
      timer_ff <= ELM_TIMER_ONE;
    end
    else if (divTick && !timerOverflow)
      timer_ff <= timer_ff + 16'h0001;
  end

  // overflow: a new overflow in the read cycle wins over the clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      overflow_ff <= 1'b0;
    else if (timerOverflow)
      overflow_ff <= 1'b1;
    else if (regRd && regAddr == ELM_REG_OVFSTAT)
      overflow_ff <= 1'b0;
  end

  assign capture = ctrl_ff[ELM_CTL_CAPSEL] ? loopTimeout
    : (regRd && regAddr == ELM_REG_COUNT);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      snap_ff <= ELM_RST_ZERO;
      intervalRes_ff <= ELM_RST_ZERO;
      elapsed_ff <= ELM_RST_ZERO;
    end
    else
    begin
      if (eetWrite)
        intervalRes_ff <= ELM_RST_ZERO;
      else if (overflow_ff || timerOverflow)
        intervalRes_ff <= ELM_CNT_FULL;
      else if (capture)
        intervalRes_ff <= interval_ff;
      if (capture)
        elapsed_ff <= timer_ff;
      if (capture && ctrl_ff[ELM_CTL_CAPSEL])
        snap_ff <= count_ff;
    end
  end

  // software-written registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff <= ELM_RST_CTRL;
      maxCnt_ff <= ELM_RST_MAXCNT;
      divider_ff <= ELM_RST_ZERO;
      decim_ff <= ELM_RST_DECIM;
    end
    else if (regWr)
    begin
      unique case (regAddr)
        ELM_REG_CTRL: ctrl_ff <= regWrData & ELM_CTL_MASK;
        ELM_REG_MAXCNT: maxCnt_ff <= regWrData;
        ELM_REG_DIVIDER: divider_ff <= regWrData;
        ELM_REG_DECIM: decim_ff <= regWrData[7:0];
        default: ;
      endcase
    end
  end

  // read data stands in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      regRdData <= ELM_RST_ZERO;
    else if (regRd)
    begin
      unique case (regAddr)
        ELM_REG_CTRL: regRdData <= ctrl_ff;
        ELM_REG_MAXCNT: regRdData <= maxCnt_ff;
        ELM_REG_COUNT: regRdData <= count_ff;
        ELM_REG_ILATCH: regRdData <= idxLatch_ff;
        ELM_REG_SLATCH: regRdData <= stbLatch_ff;
        ELM_REG_STATUS: regRdData <= {8'h00, firstSeen_ff, filt_ff, 1'b0,
          dirUp_ff, countErr_ff};
        ELM_REG_DIVIDER: regRdData <= divider_ff;
        ELM_REG_DECIM: regRdData <= {8'h00, decim_ff};
        ELM_REG_SNAP: regRdData <= snap_ff;
        ELM_REG_INTERVAL: regRdData <= intervalRes_ff;
        ELM_REG_ELAPSED: regRdData <= elapsed_ff;
        ELM_REG_OVFSTAT: regRdData <= {15'h0000, overflow_ff};
        default: regRdData <= ELM_RST_ZERO;
      endcase
    end
    else
      regRdData <= ELM_RST_ZERO;
  end

endmodule : elm_encoder_unit

// ---- sim/elm_encoder_model.sv ----
// incremental encoder model with index and strobe markers
`timescale 1ns/100ps
module elm_encoder_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stepUp,
  input wire logic stepDn,
  input wire logic idxCmd,
  input wire logic stbCmd,
  output logic quadA,
  output logic quadB,
  output logic indexMarker,
  output logic strobeMarker
);
  logic [1:0] phase_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      phase_ff <= 2'h0;
    else if (stepUp)
      phase_ff <= phase_ff + 2'h1;
    else if (stepDn)
      phase_ff <= phase_ff - 2'h1;
  end

  // gray order 00,10,11,01: one line moves per step, a leads b going up
  assign quadA = phase_ff[1] ^ phase_ff[0];
  assign quadB = phase_ff[1];
  assign indexMarker = idxCmd;
  assign strobeMarker = stbCmd;
endmodule : elm_encoder_model

// ---- sim/elm_encoder_unit_assertions.sv ----
// concurrent checks on the encoder unit register port and error pulse
`timescale 1ns/100ps
module elm_encoder_unit_assertions
  import elm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic quadAPin,
  input wire logic quadBPin,
  input wire logic indexMarkerPin,
  input wire logic strobeMarkerPin,
  input wire logic loopTimeout,
  input wire logic [ELM_AW-1:0] regAddr,
  input wire logic [ELM_DW-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [ELM_DW-1:0] regRdData,
  input wire logic countErrorEvent
);
  logic [15:0] ctrl_ff;
  logic [15:0] max_ff;
  logic [15:0] div_ff;
  logic [7:0] dec_ff;
  logic [3:0] pins_ff;
  logic [3:0] calm_ff;
  wire logic [3:0] pins = {strobeMarkerPin, indexMarkerPin, quadBPin, quadAPin};

  // mirror of the writable registers, built from the write strobes alone
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff <= ELM_RST_CTRL;
      max_ff <= ELM_RST_MAXCNT;
      div_ff <= ELM_RST_ZERO;
      dec_ff <= ELM_RST_DECIM;
    end
    else if (regWr)
    begin
      if (regAddr == ELM_REG_CTRL)
        ctrl_ff <= regWrData & ELM_CTL_MASK;
      if (regAddr == ELM_REG_MAXCNT)
        max_ff <= regWrData;
      if (regAddr == ELM_REG_DIVIDER)
        div_ff <= regWrData;
      if (regAddr == ELM_REG_DECIM)
        dec_ff <= regWrData[7:0];
    end
  end

  // pins must sit still well past the filter delay before status is judged
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins_ff <= 4'h0;
      calm_ff <= 4'h0;
    end
    else
    begin
      pins_ff <= pins;
      if (pins != pins_ff)
        calm_ff <= 4'h0;
      else if (calm_ff != 4'hf)
        calm_ff <= calm_ff + 4'h1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_rd_idle;
    !regRd |=> regRdData == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");
  property p_ctrl_rb;
    regRd && regAddr == ELM_REG_CTRL |=> regRdData == $past(ctrl_ff);
  endproperty
  a_ctrl_rb: assert property (p_ctrl_rb)
    else $error("control readback wrong");
  property p_max_rb;
    regRd && regAddr == ELM_REG_MAXCNT |=> regRdData == $past(max_ff);
  endproperty
  a_max_rb: assert property (p_max_rb)
    else $error("maximum count readback wrong");
  property p_div_rb;
    regRd && regAddr == ELM_REG_DIVIDER |=> regRdData == $past(div_ff);
  endproperty
  a_div_rb: assert property (p_div_rb)
    else $error("divider readback wrong");
  property p_dec_rb;
    regRd && regAddr == ELM_REG_DECIM |=> regRdData == {8'h00, $past(dec_ff)};
  endproperty
  a_dec_rb: assert property (p_dec_rb)
    else $error("decimation readback wrong");
  property p_unmapped;
    regRd && regAddr > ELM_REG_OVFSTAT |=> regRdData == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_err_pulse;
    countErrorEvent |=> !countErrorEvent;
  endproperty
  a_err_pulse: assert property (p_err_pulse)
    else $error("error event longer than one cycle");
  property p_err_mode;
    countErrorEvent |-> ctrl_ff[ELM_CTL_MON] && ctrl_ff[ELM_CTL_ZERO];
  endproperty
  a_err_mode: assert property (p_err_mode)
    else $error("error event with monitor off");
  property p_inputs;
    regRd && regAddr == ELM_REG_STATUS && calm_ff > 4'h9 |=> regRdData[6:3] == $past(pins);
  endproperty
  a_inputs: assert property (p_inputs)
    else $error("status input bits wrong");

  c_err: cover property (countErrorEvent);
  c_timeout: cover property (loopTimeout && ctrl_ff[ELM_CTL_CAPSEL]);
  c_latch_rd: cover property (regRd && regAddr == ELM_REG_ILATCH);
endmodule : elm_encoder_unit_assertions

// ---- sim/elm_encoder_unit_tb.sv ----
// self-checking bench for the encoder latch, monitor and event timer block
`timescale 1ns/100ps
module elm_encoder_unit_tb
  import elm_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic loopTimeout = 1'b0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWrData = 16'h0000;
  logic [15:0] rdVal;
  logic [15:0] old;
  logic stepUp = 1'b0;
  logic stepDn = 1'b0;
  logic idxCmd = 1'b0;
  logic stbCmd = 1'b0;
  wire logic qa, qb, qi, qs, countErrorEvent;
  wire logic [15:0] regRdData;
  int errorCnt = 0;
  int testsRun = 0;
  int errEvents = 0;
  int cnt = 0;
  int n;

  always #10 clk = ~clk;
  always @(posedge clk) if (countErrorEvent === 1'b1) errEvents++;

  elm_encoder_model elm_encoder_model_i (.clk(clk), .rst_n(rst_n), .stepUp(stepUp),
    .stepDn(stepDn), .idxCmd(idxCmd), .stbCmd(stbCmd), .quadA(qa), .quadB(qb),
    .indexMarker(qi), .strobeMarker(qs));
  elm_encoder_unit elm_encoder_unit_i (.clk(clk), .rst_n(rst_n), .quadAPin(qa),
    .quadBPin(qb), .indexMarkerPin(qi), .strobeMarkerPin(qs), .loopTimeout(loopTimeout),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .countErrorEvent(countErrorEvent));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    testsRun++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [3:0] a);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    rdVal = regRdData;
    @(posedge clk);
  endtask : rd

  task automatic rdc(input logic [3:0] a, input logic [15:0] e, input string what);
    rd(a);
    chk(rdVal, e, what);
  endtask : rdc

  // fixed spacing per step, so the interval between velocity events is known
  task automatic step(input logic up, input int gap);
    stepUp <= up;
    stepDn <= !up;
    @(posedge clk);
    stepUp <= 1'b0;
    stepDn <= 1'b0;
    repeat (gap - 1) @(posedge clk);
    cnt = up ? cnt + 1 : cnt - 1;
  endtask : step

  task automatic pin(input logic i, input logic s);
    idxCmd <= i;
    stbCmd <= s;
    repeat (10) @(posedge clk);
  endtask : pin

  function automatic logic [15:0] stexp(input logic [15:0] b);
    return b | {9'h000, qs, qi, qb, qa, 3'h0};
  endfunction : stexp

  task automatic finishTest;
    $display("checks %0d mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finishTest

  initial
  begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    finishTest;
  end

  initial
  begin
    void'($urandom(32'h8fa6));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 16; i++)
      rdc(i[3:0], i == 1 ? 16'hffff : i == 5 ? 16'h0002 : 16'h0000, "reset");
    wr(ELM_REG_CTRL, 16'h0006);
    repeat (5) step(1'b1, 10);
    pin(1'b1, 1'b0);
    pin(1'b0, 1'b0);
    step(1'b1, 10);
    cnt = 0;
    rdc(ELM_REG_COUNT, 16'h0000, "count");
    rdc(ELM_REG_STATUS, stexp(16'h0082), "status");
    repeat (3) step(1'b1, 10);
    pin(1'b1, 1'b0);
    pin(1'b0, 1'b0);
    step(1'b1, 10);
    rdc(ELM_REG_COUNT, cnt[15:0], "count");
    rdc(ELM_REG_ILATCH, 16'h0003, "index latch");
    wr(ELM_REG_CTRL, 16'h000a);
    step(1'b1, 10);
    pin(1'b1, 1'b0);
    pin(1'b0, 1'b0);
    step(1'b1, 10);
    rd(ELM_REG_STATUS);
    chk(rdVal & 16'h007b, stexp(16'h0003), "status error");
    chk(errEvents[15:0], 16'h0001, "error events");
    pin(1'b1, 1'b0);
    pin(1'b0, 1'b0);
    step(1'b1, 10);
    cnt = 0;
    rd(ELM_REG_STATUS);
    chk(rdVal & 16'h007b, stexp(16'h0002), "status clear");
    wr(ELM_REG_CTRL, 16'h0000);
    step(1'b0, 10);
    rdc(ELM_REG_COUNT, cnt[15:0], "roll-over");
    pin(1'b0, 1'b1);
    rd(ELM_REG_STATUS);
    chk(rdVal & 16'h007b, stexp(16'h0000), "status down");
    rdc(ELM_REG_SLATCH, 16'hffff, "strobe latch");
    pin(1'b0, 1'b0);
    n = $urandom_range(4, 2);
    repeat (n) step(1'b1, 10);
    wr(ELM_REG_COUNT, 16'($urandom));
    rdc(ELM_REG_COUNT, cnt[15:0], "count read-only");
    wr(ELM_REG_CTRL, 16'h0100);
    step(1'b0, 10);
    pin(1'b0, 1'b1);
    rdc(ELM_REG_SLATCH, 16'hffff, "strobe rise down");
    step(1'b0, 10);
    pin(1'b0, 1'b0);
    rdc(ELM_REG_SLATCH, cnt[15:0], "strobe fall");
    wr(ELM_REG_CTRL, 16'h0080);
    step(1'b1, 10);
    pin(1'b1, 1'b0);
    rdc(ELM_REG_ILATCH, 16'h0000, "index pending");
    old = cnt[15:0];
    step(1'b1, 10);
    rd(ELM_REG_ILATCH);
    chk({15'h0, rdVal === old || rdVal === cnt[15:0]}, 16'h0001, "index pulse");
    rdc(ELM_REG_COUNT, cnt[15:0], "count kept");
    pin(1'b0, 1'b0);
    wr(ELM_REG_CTRL, 16'h0000);
    wr(ELM_REG_DIVIDER, 16'h0001);
    wr(ELM_REG_DECIM, 16'h0001);
    repeat (4) step(1'b1, 10);
    rd(ELM_REG_COUNT);
    rdc(ELM_REG_INTERVAL, 16'h000a, "interval");
    wr(ELM_REG_DIVIDER, 16'h0002);
    wr(ELM_REG_DECIM, 16'h0002);
    wr(ELM_REG_CTRL, 16'h0010);
    repeat (6) step(1'b1, 12);
    rd(ELM_REG_COUNT);
    rdc(ELM_REG_INTERVAL, 16'h0000, "interval held");
    loopTimeout <= 1'b1;
    @(posedge clk);
    loopTimeout <= 1'b0;
    @(posedge clk);
    rdc(ELM_REG_INTERVAL, 16'h000d, "interval divided");
    rdc(ELM_REG_ELAPSED, 16'h0005, "elapsed");
    rdc(ELM_REG_SNAP, cnt[15:0], "snapshot");
    finishTest;
  end
endmodule : elm_encoder_unit_tb

bind elm_encoder_unit elm_encoder_unit_assertions elm_encoder_unit_assertions_i (.clk(clk),
  .rst_n(rst_n), .quadAPin(quadAPin), .quadBPin(quadBPin), .indexMarkerPin(indexMarkerPin),
  .strobeMarkerPin(strobeMarkerPin), .loopTimeout(loopTimeout), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .countErrorEvent(countErrorEvent));
